// File: core/usb_autovec.sv
// Shared USB interrupt merge and jump vector byte substitution.
// Assumes the core presents one fetch address with a valid strobe and
// the memory byte for it in the same cycle, and takes the answer one
// cycle later. Source inputs are pending levels held until serviced.
module usb_autovec
  import usb_autovec_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_AUTOVECTOR_ENABLE,
  input wire logic I_SETUP_DATA_READY,
  input wire logic I_FRAME_START,
  input wire logic I_SETUP_TOKEN_SEEN,
  input wire logic I_SUSPEND_REQ,
  input wire logic I_BUS_RESET,
  input wire logic I_HIGH_SPEED_ENTERED,
  input wire logic I_CONTROL_HANDSHAKE_ACKED,
  input wire logic I_EP0_IN_READY,
  input wire logic I_EP0_OUT_DATA,
  input wire logic I_EP1_IN_READY,
  input wire logic I_EP1_OUT_DATA,
  input wire logic I_EP2_BUF,
  input wire logic I_EP4_BUF,
  input wire logic I_EP6_BUF,
  input wire logic I_EP8_BUF,
  input wire logic I_IN_BULK_NAK,
  input wire logic I_EP0_PING_NAK,
  input wire logic I_EP1_PING_NAK,
  input wire logic I_EP2_PING_NAK,
  input wire logic I_EP4_PING_NAK,
  input wire logic I_EP6_PING_NAK,
  input wire logic I_EP8_PING_NAK,
  input wire logic I_BUS_ERROR_LIMIT_HIT,
  input wire logic I_EP2_ISO_PID_ERROR,
  input wire logic I_EP4_ISO_PID_ERROR,
  input wire logic I_EP6_ISO_PID_ERROR,
  input wire logic I_EP8_ISO_PID_ERROR,
  input wire logic I_FETCH_VALID,
  input wire logic [15:0] I_FETCH_ADDR,
  input wire logic [7:0] I_MEM_DATA,
  output logic O_SHARED_USB_INTERRUPT,
  output logic O_FETCH_VALID,
  output logic [7:0] O_FETCH_DATA,
  output logic O_SUBSTITUTED
);

  // ******************************************************************
  // Source gathering
  // ******************************************************************
  logic [NUM_SRC-1:0] src;
  logic any_pending;
  logic [7:0] usb_vector_code;
  logic at_vector;
  logic next_subst;

  // Index order equals priority order, so index 0 is the most urgent
  assign src = {
    I_EP8_ISO_PID_ERROR, I_EP6_ISO_PID_ERROR,
    I_EP4_ISO_PID_ERROR, I_EP2_ISO_PID_ERROR,
    I_BUS_ERROR_LIMIT_HIT,
    I_EP8_PING_NAK, I_EP6_PING_NAK, I_EP4_PING_NAK,
    I_EP2_PING_NAK, I_EP1_PING_NAK, I_EP0_PING_NAK,
    I_IN_BULK_NAK,
    I_EP8_BUF, I_EP6_BUF, I_EP4_BUF, I_EP2_BUF,
    I_EP1_OUT_DATA, I_EP1_IN_READY,
    I_EP0_OUT_DATA, I_EP0_IN_READY,
    I_CONTROL_HANDSHAKE_ACKED,
    I_HIGH_SPEED_ENTERED, I_BUS_RESET,
    I_SUSPEND_REQ,
    I_SETUP_TOKEN_SEEN, I_FRAME_START,
    I_SETUP_DATA_READY
  };

  // Pick the winning code; reserved slots have no source at all
  usb_vec_encoder #(
    .N(NUM_SRC)
  ) u_enc (
    .i_src(src),
    .o_any(any_pending),
    .o_code(usb_vector_code)
  );

  // ******************************************************************
  // Shared interrupt request
  // ******************************************************************
  // Level request; the core vectors to the jump at 0x0043 itself
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_SHARED_USB_INTERRUPT <= 1'b0;
    end else begin
      O_SHARED_USB_INTERRUPT <= any_pending;
    end
  end

  // ******************************************************************
  // Fetch byte substitution
  // ******************************************************************
  // Only the low address byte of the jump is touched; the opcode at
  // 0x0043 and the page at 0x0044 come from memory
  assign at_vector = I_FETCH_VALID && (I_FETCH_ADDR == ADDR_VECTOR);
  // No pending source means no valid code, so memory is kept then
  assign next_subst = at_vector && I_AUTOVECTOR_ENABLE && any_pending;

  // Code is sampled at the fetch itself, so a source arriving later
  // cannot tear a half-fetched jump
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_FETCH_DATA <= FETCH_DATA_RST;
      O_SUBSTITUTED <= 1'b0;
    end else begin
      O_SUBSTITUTED <= next_subst;
      if (next_subst) begin
        O_FETCH_DATA <= usb_vector_code;
      end else begin
        O_FETCH_DATA <= I_MEM_DATA;
      end
    end
  end

  // Answer strobe follows each fetch by one cycle
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_FETCH_VALID <= 1'b0;
    end else begin
      O_FETCH_VALID <= I_FETCH_VALID;
    end
  end

  // ******************************************************************
  // Assertions
  // ******************************************************************
  logic only_iso8;
  assign only_iso8 = I_EP8_ISO_PID_ERROR && (src[NUM_SRC-2:0] == '0);

  property p_irq_set;
    @(posedge I_CLK) disable iff (!I_NRST)
      (|src) |=> O_SHARED_USB_INTERRUPT;
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("pending source did not raise interrupt");

  property p_irq_drop;
    @(posedge I_CLK) disable iff (!I_NRST)
      (src == '0) |=> !O_SHARED_USB_INTERRUPT;
  endproperty
  a_irq_drop: assert property (p_irq_drop)
    else $error("interrupt high with nothing pending");

  property p_opcode_pass;
    @(posedge I_CLK) disable iff (!I_NRST)
      (I_FETCH_VALID && I_FETCH_ADDR == ADDR_JUMP_OP) |=>
        (O_FETCH_VALID && O_FETCH_DATA == $past(I_MEM_DATA));
  endproperty
  a_opcode_pass: assert property (p_opcode_pass)
    else $error("jump opcode byte altered");

  property p_page_pass;
    @(posedge I_CLK) disable iff (!I_NRST)
      (I_FETCH_VALID && I_FETCH_ADDR == ADDR_PAGE) |=>
        (O_FETCH_DATA == $past(I_MEM_DATA) && !O_SUBSTITUTED);
  endproperty
  a_page_pass: assert property (p_page_pass)
    else $error("page byte altered");

  property p_subst;
    @(posedge I_CLK) disable iff (!I_NRST)
      (at_vector && I_AUTOVECTOR_ENABLE && (|src)) |=>
        (O_SUBSTITUTED && O_FETCH_DATA == $past(usb_vector_code));
  endproperty
  a_subst: assert property (p_subst)
    else $error("vector byte not substituted");

  property p_top_priority;
    @(posedge I_CLK) disable iff (!I_NRST)
      (at_vector && I_AUTOVECTOR_ENABLE && I_SETUP_DATA_READY) |=>
        (O_FETCH_DATA == 8'h00);
  endproperty
  a_top_priority: assert property (p_top_priority)
    else $error("setup data did not win priority");

  property p_iso8;
    @(posedge I_CLK) disable iff (!I_NRST)
      (at_vector && I_AUTOVECTOR_ENABLE && only_iso8) |=>
        (O_FETCH_DATA == 8'h7C);
  endproperty
  a_iso8: assert property (p_iso8)
    else $error("wrong code for endpoint 8 iso error");

  property p_disabled;
    @(posedge I_CLK) disable iff (!I_NRST)
      (I_FETCH_VALID && !I_AUTOVECTOR_ENABLE) |=>
        (!O_SUBSTITUTED && O_FETCH_DATA == $past(I_MEM_DATA));
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("substitution while autovector disabled");

  property p_aligned;
    @(posedge I_CLK) disable iff (!I_NRST)
      O_SUBSTITUTED |-> (O_FETCH_DATA[1:0] == 2'b00);
  endproperty
  a_aligned: assert property (p_aligned)
    else $error("vector code not a multiple of four");

  property p_no_reserved;
    @(posedge I_CLK) disable iff (!I_NRST)
      O_SUBSTITUTED |-> !(O_FETCH_DATA inside
        {8'h1C, 8'h44, 8'h64, 8'h68, 8'h6C});
  endproperty
  a_no_reserved: assert property (p_no_reserved)
    else $error("reserved vector code produced");

  property p_cov_subst;
    @(posedge I_CLK) disable iff (!I_NRST) O_SUBSTITUTED;
  endproperty
  c_cov_subst: cover property (p_cov_subst);

  property p_cov_multi;
    @(posedge I_CLK) disable iff (!I_NRST)
      next_subst && ($countones(src) > 1);
  endproperty
  c_cov_multi: cover property (p_cov_multi);

  property p_cov_jump_seq;
    @(posedge I_CLK) disable iff (!I_NRST)
      (I_FETCH_VALID && I_FETCH_ADDR == ADDR_JUMP_OP) ##1
      (I_FETCH_VALID && I_FETCH_ADDR == ADDR_PAGE) ##1 next_subst;
  endproperty
  c_cov_jump_seq: cover property (p_cov_jump_seq);

endmodule : usb_autovec

// File: core/usb_autovec_pkg.sv
// Constants for the shared USB interrupt autovector logic.
// Assumes a byte-wide instruction fetch path from an 8051-class core.
package usb_autovec_pkg;

  // ******************************************************************
  // Fetch addresses and widths
  // ******************************************************************
  localparam int NUM_SRC = 27;
  localparam logic [15:0] ADDR_JUMP_OP = 16'h0043;
  localparam logic [15:0] ADDR_PAGE = 16'h0044;
  localparam logic [15:0] ADDR_VECTOR = 16'h0045;
  localparam logic [7:0] FETCH_DATA_RST = 8'h00;

  // ******************************************************************
  // Vector code per source, index 0 is the highest priority
  // ******************************************************************
  // Listed from index 26 down to index 0; all multiples of four
  localparam logic [NUM_SRC-1:0][7:0] SRC_CODE = {
    8'h7C, 8'h78, 8'h74, 8'h70,               // Iso PID errors
    8'h60,                                    // Error limit
    8'h5C, 8'h58, 8'h54, 8'h50, 8'h4C, 8'h48, // Ping NAKs
    8'h40,                                    // In bulk NAK
    8'h3C, 8'h38, 8'h34, 8'h30,               // Buffers
    8'h2C, 8'h28,                             // Endpoint one
    8'h24, 8'h20,                             // Endpoint zero
    8'h18,                                    // Handshake
    8'h14, 8'h10, 8'h0C,                      // Bus state
    8'h08, 8'h04, 8'h00                       // Setup, frame
  };

endpackage : usb_autovec_pkg

// File: core/usb_vec_encoder.sv
// Priority encoder from pending USB sources to a vector code.
// Assumes source index 0 is the most urgent one.
module usb_vec_encoder
  import usb_autovec_pkg::*;
#(
  parameter int N = NUM_SRC
) (
  input wire logic [N-1:0] i_src,
  output logic o_any,
  output logic [7:0] o_code
);

  // ******************************************************************
  // Lowest pending index wins
  // ******************************************************************
  function automatic logic [7:0] pick_code(input logic [N-1:0] src);
    logic [7:0] code;
    code = 8'h00;
    // Walk downwards so the last hit is the lowest index
    for (int i = N - 1; i >= 0; i--) begin
      if (src[i]) begin
        code = SRC_CODE[i];
      end
    end
    return code;
  endfunction : pick_code

  // Combinational result; the top registers it
  always_comb begin
    o_any = |i_src;
    o_code = pick_code(i_src);
  end

endmodule : usb_vec_encoder

// File: tb/core_fetch_model.sv
// Behavioural processor core that fetches the shared interrupt jump.
// Assumes every fetch is answered one clock after the edge that takes it.
module core_fetch_model (
  input wire logic clk,
  output logic fetch_valid,
  output logic [15:0] fetch_addr,
  output logic [7:0] mem_data,
  input wire logic ans_valid,
  input wire logic [7:0] ans_data,
  input wire logic ans_sub
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy = 1'b0;

  initial begin
    fetch_valid = 1'b0;
    fetch_addr = 16'h0000;
    mem_data = 8'h00;
  end

  // Idle lines churn, so a stale address or byte is never held for two cycles
  always @(posedge clk) begin
    if (!busy) begin
      fetch_addr <= ~fetch_addr;
      mem_data <= mem_data + 8'h35;
    end
  end

  // ****************************************************************
  // Three back-to-back byte fetches of the long jump
  // ****************************************************************
  task automatic jump_fetch(input logic [7:0] page, input logic [7:0] low,
    output logic [23:0] data, output logic [2:0] sub,
    output logic [2:0] vld);
    logic [15:0] a [3];
    logic [7:0] m [3];
    a = '{16'h0043, 16'h0044, 16'h0045};
    m = '{8'h02, page, low};
    busy = 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      fetch_valid <= (k < 3);
      if (k < 3) begin
        fetch_addr <= a[k];
        mem_data <= m[k];
      end
      // Answer of the previous byte is read mid-cycle, once settled
      if (k > 0) begin
        @(negedge clk);
        data[8*(k-1) +: 8] = ans_data;
        sub[k-1] = ans_sub;
        vld[k-1] = ans_valid;
      end
    end
    busy = 1'b0;
  endtask : jump_fetch
endmodule : core_fetch_model

// File: tb/tb.sv
// Self-checking bench for the shared USB interrupt autovector block.
// Assumes the core model drives the fetch port and reads back the answers.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic en = 1'b0;
  logic [26:0] src = '0;
  logic fv, ov, sub, intr;
  logic [15:0] fa;
  logic [7:0] md, fd;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  usb_autovec uut (
    .I_CLK(clk), .I_NRST(nrst), .I_AUTOVECTOR_ENABLE(en),
    .I_SETUP_DATA_READY(src[0]), .I_FRAME_START(src[1]),
    .I_SETUP_TOKEN_SEEN(src[2]), .I_SUSPEND_REQ(src[3]),
    .I_BUS_RESET(src[4]), .I_HIGH_SPEED_ENTERED(src[5]),
    .I_CONTROL_HANDSHAKE_ACKED(src[6]), .I_EP0_IN_READY(src[7]),
    .I_EP0_OUT_DATA(src[8]), .I_EP1_IN_READY(src[9]),
    .I_EP1_OUT_DATA(src[10]), .I_EP2_BUF(src[11]), .I_EP4_BUF(src[12]),
    .I_EP6_BUF(src[13]), .I_EP8_BUF(src[14]), .I_IN_BULK_NAK(src[15]),
    .I_EP0_PING_NAK(src[16]), .I_EP1_PING_NAK(src[17]),
    .I_EP2_PING_NAK(src[18]), .I_EP4_PING_NAK(src[19]),
    .I_EP6_PING_NAK(src[20]), .I_EP8_PING_NAK(src[21]),
    .I_BUS_ERROR_LIMIT_HIT(src[22]), .I_EP2_ISO_PID_ERROR(src[23]),
    .I_EP4_ISO_PID_ERROR(src[24]), .I_EP6_ISO_PID_ERROR(src[25]),
    .I_EP8_ISO_PID_ERROR(src[26]), .I_FETCH_VALID(fv),
    .I_FETCH_ADDR(fa), .I_MEM_DATA(md), .O_SHARED_USB_INTERRUPT(intr),
    .O_FETCH_VALID(ov), .O_FETCH_DATA(fd), .O_SUBSTITUTED(sub)
  );

  core_fetch_model core (
    .clk(clk), .fetch_valid(fv), .fetch_addr(fa), .mem_data(md),
    .ans_valid(ov), .ans_data(fd), .ans_sub(sub)
  );

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    if (errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // Codes skip the reserved slots 1C, 44 and 64 to 6C
  function automatic logic [7:0] code_of(input int i);
    int s;
    s = (i < 7) ? i : (i < 16) ? i + 1 : (i < 23) ? i + 2 : i + 5;
    return 8'(4 * s);
  endfunction : code_of

  task automatic drive(input logic [26:0] v, input logic e);
    @(posedge clk);
    src <= v;
    en <= e;
  endtask : drive

  // Source levels are sampled one edge after they are driven
  task automatic check_intr(input logic exp);
    @(posedge clk);
    @(negedge clk);
    check({7'h00, intr}, {7'h00, exp});
  endtask : check_intr

  task automatic jump(input logic [7:0] low, input logic [7:0] code,
    input logic s);
    logic [23:0] d;
    logic [2:0] su;
    logic [2:0] v;
    core.jump_fetch(8'hA7, low, d, su, v);
    check(d[7:0], 8'h02);
    check(d[15:8], 8'hA7);
    check(d[23:16], code);
    check({5'h00, su}, {5'h00, s, 2'b00});
    check({5'h00, v}, 8'h07);
  endtask : jump

  task automatic check_idle;
    check({5'h00, intr, ov, sub}, 8'h00);
    check(fd, 8'h00);
  endtask : check_idle

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_each;
    for (int i = 0; i < 27; i++) begin
      drive(27'(1) << i, 1'b1);
      check_intr(1'b1);
      jump(8'h5A, code_of(i), 1'b1);
    end
  endtask : t_each

  task automatic t_priority;
    for (int i = 0; i < 27; i++) begin
      drive(~((27'(1) << i) - 27'(1)), 1'b1);
      jump(8'hC3, code_of(i), 1'b1);
    end
  endtask : t_priority

  // Disabled substitution and nothing pending both pass memory through
  task automatic t_pass;
    drive('1, 1'b0);
    jump(8'h3C, 8'h3C, 1'b0);
    drive('0, 1'b1);
    check_intr(1'b0);
    jump(8'h81, 8'h81, 1'b0);
  endtask : t_pass

  // Flag falls exactly one cycle after its last source clears
  task automatic t_clear;
    drive(27'h0000010, 1'b1);
    check_intr(1'b1);
    drive('0, 1'b1);
    @(negedge clk);
    check({7'h00, intr}, 8'h01);
    @(negedge clk);
    check({7'h00, intr}, 8'h00);
  endtask : t_clear

  task automatic t_midreset;
    drive(27'h4000000, 1'b1);
    jump(8'h11, 8'h7C, 1'b1);
    drive('1, 1'b1);
    nrst <= 1'b0;
    @(negedge clk);
    check_idle();
    @(posedge clk);
    nrst <= 1'b1;
    check_intr(1'b1);
    jump(8'h11, 8'h00, 1'b1);
  endtask : t_midreset

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    repeat (2) @(negedge clk);
    check_idle();
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_each();
    t_priority();
    t_pass();
    t_clear();
    t_midreset();
    summarize();
  end
endmodule : tb
